// [hw/dff_pkg.sv]
package dff_pkg;
   // Register offsets on the control port
   localparam logic [7:0] ADDR_FILTER = 8'h4a;  // Debounce and threshold scale
   localparam logic [7:0] ADDR_AVG    = 8'h4b;  // Moving average setup
   localparam logic [7:0] ADDR_HI     = 8'h4c;  // Supply high current limit
   localparam logic [7:0] ADDR_LO     = 8'h4d;  // Supply low current limit
   localparam logic [7:0] ADDR_UP     = 8'h4e;  // Aux analog upper limit
   localparam logic [7:0] ADDR_DN     = 8'h4f;  // Aux analog lower limit
   localparam logic [7:0] ADDR_ACT    = 8'h50;  // Supply fault action
   // Reset values
   localparam logic [7:0] RST_FILTER  = 8'h08;
   localparam logic [7:0] RST_AVG     = 8'h00;
   localparam logic [7:0] RST_HI      = 8'ha2;
   localparam logic [7:0] RST_LO      = 8'h48;
   localparam logic [7:0] RST_UP      = 8'hba;
   localparam logic [7:0] RST_DN      = 8'h4b;
   localparam logic [7:0] RST_ACT     = 8'h88;
   // Writable bits, reserved bits stay zero
   localparam logic [7:0] MASK_FILTER = 8'h0f;
   localparam logic [7:0] MASK_AVG    = 8'hf8;
   // Field positions
   localparam int DEB_LSB      = 2;
   localparam int BSHORT_BIT   = 1;
   localparam int DOUBLE_BIT   = 0;
   localparam int AVGSEL_LSB   = 6;
   localparam int OFF_LOAD_BIT = 5;
   localparam int OFF_TEMP_BIT = 4;
   localparam int OFF_AUX_BIT  = 3;
   // Measurement channels
   localparam int            MEAS_W  = 12;
   localparam logic [1:0]    CH_LOAD = 2'h0;
   localparam logic [1:0]    CH_TEMP = 2'h1;
   localparam logic [1:0]    CH_AUX  = 2'h2;
   // Averaging modes
   localparam logic [1:0] AVG_OFF     = 2'h0;
   localparam logic [1:0] AVG_HALF    = 2'h1;
   localparam logic [1:0] AVG_QUARTER = 2'h2;
   // Debounce targets
   localparam logic [4:0] DEB16 = 5'h10;
   localparam logic [4:0] DEB8  = 5'h08;
   localparam logic [4:0] DEB4  = 5'h04;
   localparam logic [4:0] DEB1  = 5'h01;
   // Limit code scaling: code times 16
   localparam int THR_SHIFT = 4;

   // One measurement sample
   typedef struct packed {
      logic              valid;
      logic [1:0]        chan;
      logic [MEAS_W-1:0] data;
   } dff_meas_t;

   // Debounced fault flags
   typedef struct packed {
      logic batt_short;
      logic aux_lower;
      logic aux_upper;
      logic supply_low;
      logic supply_high;
   } dff_faults_t;
endpackage : dff_pkg

// [hw/dff_fault_filter.sv]
`timescale 1ns/1ps
module dff_fault_filter #(
   parameter int DEB_W = 5                              // Debounce counter width
) (
   input  wire logic                clk_i,
   input  wire logic                reset_i,
   input  wire logic [7:0]          reg_addr_i,        // Control port address
   input  wire logic                reg_wr_i,          // Write strobe
   input  wire logic [7:0]          reg_wdata_i,       // Write data
   input  wire logic                reg_rd_i,          // Read strobe
   input  wire dff_pkg::dff_meas_t  meas_i,            // Raw measurement sample
   input  wire logic                batt_valid_i,      // Battery short sample taken
   input  wire logic                batt_hit_i,        // Battery short detected
   input  wire logic                batt_below_i,      // Battery input below supply
   output logic [7:0]               reg_rdata_o,       // Read data
   output dff_pkg::dff_meas_t       filt_o,            // Filtered sample
   output dff_pkg::dff_faults_t     fault_o,           // Debounced faults
   output logic [7:0]               supply_action_o    // Supply fault action bits
);
   if (DEB_W < $bits(dff_pkg::DEB16)) begin : g_deb_w_chk
      $error("DEB_W too small for a count of 16");
   end

   // Configuration registers
   logic [7:0] filter_ff, avg_ff, hi_ff, lo_ff, up_ff, dn_ff, act_ff, rdata_ff;
   logic [7:0] nxt_filter, nxt_avg, nxt_hi, nxt_lo, nxt_up, nxt_dn, nxt_act, nxt_rdata;

   // Register writes and reads
   always_comb begin
      nxt_filter = filter_ff;
      nxt_avg    = avg_ff;
      nxt_hi     = hi_ff;
      nxt_lo     = lo_ff;
      nxt_up     = up_ff;
      nxt_dn     = dn_ff;
      nxt_act    = act_ff;
      nxt_rdata  = rdata_ff;
      if (reg_wr_i) begin
         if (reg_addr_i == dff_pkg::ADDR_FILTER) begin
            nxt_filter = reg_wdata_i & dff_pkg::MASK_FILTER;
         end else if (reg_addr_i == dff_pkg::ADDR_AVG) begin
            nxt_avg = reg_wdata_i & dff_pkg::MASK_AVG;
         end else if (reg_addr_i == dff_pkg::ADDR_HI) begin
            nxt_hi = reg_wdata_i;
         end else if (reg_addr_i == dff_pkg::ADDR_LO) begin
            nxt_lo = reg_wdata_i;
         end else if (reg_addr_i == dff_pkg::ADDR_UP) begin
            nxt_up = reg_wdata_i;
         end else if (reg_addr_i == dff_pkg::ADDR_DN) begin
            nxt_dn = reg_wdata_i;
         end else if (reg_addr_i == dff_pkg::ADDR_ACT) begin
            nxt_act = reg_wdata_i;
         end
      end
      if (reg_rd_i) begin
         if (reg_addr_i == dff_pkg::ADDR_FILTER) begin
            nxt_rdata = filter_ff;
         end else if (reg_addr_i == dff_pkg::ADDR_AVG) begin
            nxt_rdata = avg_ff;
         end else if (reg_addr_i == dff_pkg::ADDR_HI) begin
            nxt_rdata = hi_ff;
         end else if (reg_addr_i == dff_pkg::ADDR_LO) begin
            nxt_rdata = lo_ff;
         end else if (reg_addr_i == dff_pkg::ADDR_UP) begin
            nxt_rdata = up_ff;
         end else if (reg_addr_i == dff_pkg::ADDR_DN) begin
            nxt_rdata = dn_ff;
         end else if (reg_addr_i == dff_pkg::ADDR_ACT) begin
            nxt_rdata = act_ff;
         end else begin
            nxt_rdata = 8'h00;  // Unmapped reads zero
         end
      end
   end

   // Register storage
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         filter_ff <= dff_pkg::RST_FILTER;
         avg_ff    <= dff_pkg::RST_AVG;
         hi_ff     <= dff_pkg::RST_HI;
         lo_ff     <= dff_pkg::RST_LO;
         up_ff     <= dff_pkg::RST_UP;
         dn_ff     <= dff_pkg::RST_DN;
         act_ff    <= dff_pkg::RST_ACT;
         rdata_ff  <= 8'h00;
      end else begin
         filter_ff <= nxt_filter;
         avg_ff    <= nxt_avg;
         hi_ff     <= nxt_hi;
         lo_ff     <= nxt_lo;
         up_ff     <= nxt_up;
         dn_ff     <= nxt_dn;
         act_ff    <= nxt_act;
         rdata_ff  <= nxt_rdata;
      end
   end

   // Debounce target from a select code
   function automatic logic [4:0] deb_target(input logic [1:0] sel);
      case (sel)
         2'h0:    deb_target = dff_pkg::DEB16;
         2'h1:    deb_target = dff_pkg::DEB8;
         2'h2:    deb_target = dff_pkg::DEB4;
         default: deb_target = dff_pkg::DEB1;
      endcase
   endfunction : deb_target

   // Limit code to 13-bit compare value
   function automatic logic [12:0] scale_thr(input logic [7:0] code, input logic dbl);
      logic [12:0] base;
      base      = {1'b0, code, 4'h0};
      scale_thr = dbl ? {base[11:0], 1'b0} : base;
   endfunction : scale_thr

   // Moving average of old and new data
   function automatic logic [11:0] avg_calc(input logic [1:0] mode, input logic [11:0] old,
                                            input logic [11:0] cur);
      logic [13:0] sum;
      sum = 14'h0000;
      case (mode)
         dff_pkg::AVG_HALF: begin
            sum      = {2'h0, old} + {2'h0, cur};
            avg_calc = sum[12:1];
         end
         dff_pkg::AVG_QUARTER: begin
            sum      = {1'b0, old, 1'b0} + {2'h0, old} + {2'h0, cur};
            avg_calc = sum[13:2];
         end
         default: avg_calc = cur;                  // Off or reserved code
      endcase
   endfunction : avg_calc

   // Filter state per channel
   logic [11:0]       hist_ff [3];
   logic [2:0]        primed_ff, nxt_primed;
   logic [11:0]       nxt_hist [3];
   dff_pkg::dff_meas_t filt_ff, nxt_filt;
   logic [2:0]        off_bits;
   logic [11:0]       avg_now;

   // Filter next state
   always_comb begin
      off_bits = {avg_ff[dff_pkg::OFF_AUX_BIT], avg_ff[dff_pkg::OFF_TEMP_BIT],
                  avg_ff[dff_pkg::OFF_LOAD_BIT]};
      nxt_hist   = hist_ff;
      nxt_primed = primed_ff;
      avg_now    = meas_i.data;
      if (meas_i.valid && meas_i.chan <= dff_pkg::CH_AUX) begin
         if (!off_bits[meas_i.chan] && primed_ff[meas_i.chan]) begin
            avg_now = avg_calc(avg_ff[dff_pkg::AVGSEL_LSB +: 2], hist_ff[meas_i.chan], meas_i.data);
         end
         nxt_hist[meas_i.chan]   = avg_now;
         nxt_primed[meas_i.chan] = 1'b1;
      end
      nxt_filt.valid = meas_i.valid && meas_i.chan <= dff_pkg::CH_AUX;
      nxt_filt.chan  = meas_i.chan;
      nxt_filt.data  = avg_now;
   end

   // Filter registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hist_ff   <= '{default: 12'h000};
         primed_ff <= 3'h0;
         filt_ff   <= '0;
      end else begin
         hist_ff   <= nxt_hist;
         primed_ff <= nxt_primed;
         filt_ff   <= nxt_filt;
      end
   end

   // Debounce state: 0 high, 1 low, 2 upper, 3 lower, 4 battery
   logic [DEB_W-1:0]  cnt_ff [5];
   logic [DEB_W-1:0]  nxt_cnt [5];
   logic [4:0]        flag_ff, nxt_flag, ev, hit;
   logic [4:0]        tgt [5];
   logic              dbl;

   // Compare and debounce next state
   always_comb begin
      dbl    = filter_ff[dff_pkg::DOUBLE_BIT];
      ev[0]  = nxt_filt.valid && meas_i.chan == dff_pkg::CH_LOAD;
      ev[1]  = ev[0];
      ev[2]  = nxt_filt.valid && meas_i.chan == dff_pkg::CH_AUX;
      ev[3]  = ev[2];
      ev[4]  = batt_valid_i;
      hit[0] = {1'b0, avg_now} > scale_thr(hi_ff, dbl);
      hit[1] = {1'b0, avg_now} < scale_thr(lo_ff, dbl);
      hit[2] = {1'b0, avg_now} > scale_thr(up_ff, dbl);
      hit[3] = {1'b0, avg_now} < scale_thr(dn_ff, dbl);
      hit[4] = batt_hit_i;
      for (int i = 0; i < 4; i++) begin
         tgt[i] = deb_target(filter_ff[dff_pkg::DEB_LSB +: 2]);
      end
      tgt[4] = batt_below_i ? (filter_ff[dff_pkg::BSHORT_BIT] ? dff_pkg::DEB8 : dff_pkg::DEB16)
                            : deb_target(filter_ff[dff_pkg::DEB_LSB +: 2]);
      nxt_cnt  = cnt_ff;
      nxt_flag = flag_ff;
      for (int i = 0; i < 5; i++) begin
         if (ev[i]) begin
            if (hit[i]) begin
               if (cnt_ff[i] < DEB_W'(tgt[i])) begin
                  nxt_cnt[i] = cnt_ff[i] + 1'b1;
               end
               nxt_flag[i] = nxt_cnt[i] >= DEB_W'(tgt[i]);
            end else begin
               nxt_cnt[i]  = '0;
               nxt_flag[i] = 1'b0;
            end
         end
      end
   end

   // Debounce registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_ff  <= '{default: '0};
         flag_ff <= 5'h00;
      end else begin
         cnt_ff  <= nxt_cnt;
         flag_ff <= nxt_flag;
      end
   end

   assign reg_rdata_o     = rdata_ff;
   assign filt_o          = filt_ff;
   assign fault_o         = flag_ff;
   assign supply_action_o = act_ff;

   // Checks
   property p_deb_rst;
      @(posedge clk_i) $fell(reset_i) |-> filter_ff[3:2] == 2'h2 && filter_ff[1] == 1'b0;
   endproperty
   a_deb_rst: assert property (p_deb_rst) else $error("debounce reset value wrong");
   property p_lim_rst;
      @(posedge clk_i) $fell(reset_i) |-> hi_ff == dff_pkg::RST_HI && lo_ff == dff_pkg::RST_LO
         && up_ff == dff_pkg::RST_UP && dn_ff == dff_pkg::RST_DN;
   endproperty
   a_lim_rst: assert property (p_lim_rst) else $error("limit reset value wrong");
   property p_no_deb;
      @(posedge clk_i) disable iff (reset_i)
         filter_ff[3:2] == 2'h3 && ev[0] && hit[0] |=> fault_o.supply_high;
   endproperty
   a_no_deb: assert property (p_no_deb) else $error("undebounced fault not raised");
   property p_deb16;
      @(posedge clk_i) disable iff (reset_i)
         filter_ff[3:2] == 2'h0 && ev[0] && hit[0] && cnt_ff[0] == 5'h0e |=> !fault_o.supply_high;
   endproperty
   a_deb16: assert property (p_deb16) else $error("fault raised before sixteen hits");
   property p_miss;
      @(posedge clk_i) disable iff (reset_i) ev[1] && !hit[1] |=> cnt_ff[1] == '0 && !fault_o.supply_low;
   endproperty
   a_miss: assert property (p_miss) else $error("miss did not restart count");
   property p_batt8;
      @(posedge clk_i) disable iff (reset_i)
         batt_below_i && filter_ff[1] && batt_valid_i && batt_hit_i && cnt_ff[4] == 5'h07 |=> fault_o.batt_short;
   endproperty
   a_batt8: assert property (p_batt8) else $error("battery short not raised at eight");
   property p_double;
      @(posedge clk_i) disable iff (reset_i)
         ev[0] && filter_ff[0] |-> hit[0] == ({1'b0, avg_now} > {hi_ff, 5'h00});
   endproperty
   a_double: assert property (p_double) else $error("doubled limit not applied");
   property p_half;
      @(posedge clk_i) disable iff (reset_i)
         ev[0] && avg_ff[7:5] == 3'h2 && primed_ff[0] |=>
         2 * filt_o.data == $past(hist_ff[0]) + $past(meas_i.data)
         || 2 * filt_o.data + 1 == $past(hist_ff[0]) + $past(meas_i.data);
   endproperty
   a_half: assert property (p_half) else $error("half average wrong");
   property p_bypass;
      @(posedge clk_i) disable iff (reset_i) ev[2] && avg_ff[3] |=> filt_o.data == $past(meas_i.data);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not honoured");
   property p_low;
      @(posedge clk_i) disable iff (reset_i) fault_o.aux_lower && !$past(reset_i) |-> $past(hit[3]) || $past(!ev[3]);
   endproperty
   a_low: assert property (p_low) else $error("lower fault without cause");
   c_high: cover property (@(posedge clk_i) $rose(fault_o.supply_high));
   c_batt: cover property (@(posedge clk_i) $rose(fault_o.batt_short));
   c_quarter: cover property (@(posedge clk_i) ev[0] && avg_ff[7:6] == 2'h2 && primed_ff[0]);
endmodule : dff_fault_filter

// [tb/tb_dff_fault_filter.sv]
`timescale 1ns/1ps
module tb_dff_fault_filter;
   // Register table row: address, write flag, write data, expected read
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wd;
      logic [7:0] ex;
   } dff_row_t;

   logic                 clk_i        = 1'b0;   // Device clock
   logic                 reset_i      = 1'b1;   // Sync reset, high
   logic [7:0]           reg_addr_i   = 8'h00;  // Control port address
   logic                 reg_wr_i     = 1'b0;   // Write strobe
   logic [7:0]           reg_wdata_i  = 8'h00;  // Write data
   logic                 reg_rd_i     = 1'b0;   // Read strobe
   dff_pkg::dff_meas_t   meas_i       = '0;     // Raw sample
   logic                 batt_valid_i = 1'b0;   // Battery sample strobe
   logic                 batt_hit_i   = 1'b0;   // Battery short seen
   logic                 batt_below_i = 1'b0;   // Battery below supply
   logic [7:0]           reg_rdata_o;           // Read data
   dff_pkg::dff_meas_t   filt_o;                // Filtered sample
   dff_pkg::dff_faults_t fault_o;               // Debounced faults
   logic [7:0]           supply_action_o;       // Action register copy
   dff_pkg::dff_meas_t   fl;                    // Captured filtered sample
   dff_pkg::dff_faults_t ft;                    // Captured faults
   int                   error_cnt    = 0;      // Mismatches
   int                   tests_run    = 0;      // Comparisons
   dff_row_t             rows [22];             // Register cases

   // Device under test
   dff_fault_filter i_dut (
      .clk_i           (clk_i),
      .reset_i         (reset_i),
      .reg_addr_i      (reg_addr_i),
      .reg_wr_i        (reg_wr_i),
      .reg_wdata_i     (reg_wdata_i),
      .reg_rd_i        (reg_rd_i),
      .meas_i          (meas_i),
      .batt_valid_i    (batt_valid_i),
      .batt_hit_i      (batt_hit_i),
      .batt_below_i    (batt_below_i),
      .reg_rdata_o     (reg_rdata_o),
      .filt_o          (filt_o),
      .fault_o         (fault_o),
      .supply_action_o (supply_action_o)
   );

   // Free running 8 ns clock
   initial begin
      forever #4 clk_i = ~clk_i;
   end

   // Verdict and end of run
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   // Compare one register byte
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t ns: byte got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   // Compare one flag
   task automatic chk1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t ns: flag got %b expected %b", $time, got, exp);
      end
   endtask : chk1

   // Compare one sample value
   task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t ns: sample got %h expected %h", $time, got, exp);
      end
   endtask : chk12

   // Register write, one strobe cycle then one idle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i  = a;
      reg_wdata_i = d;
      reg_wr_i    = 1'b1;
      @(posedge clk_i);
      #1;
      reg_wr_i = 1'b0;
      @(posedge clk_i);
      #1;
   endtask : wr

   // Register read, data lands at the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr_i = a;
      reg_rd_i   = 1'b1;
      @(posedge clk_i);
      #1;
      d        = reg_rdata_o;
      reg_rd_i = 1'b0;
      @(posedge clk_i);
      #1;
   endtask : rd

   // One measurement sample, outputs captured one cycle later
   task automatic send(input logic [1:0] ch, input logic [11:0] d);
      meas_i = '{valid: 1'b1, chan: ch, data: d};
      @(posedge clk_i);
      #1;
      fl           = filt_o;
      ft           = fault_o;
      meas_i.valid = 1'b0;
      @(posedge clk_i);
      #1;
   endtask : send

   // One battery short sample
   task automatic bsend(input logic hit);
      batt_valid_i = 1'b1;
      batt_hit_i   = hit;
      @(posedge clk_i);
      #1;
      ft           = fault_o;
      batt_valid_i = 1'b0;
      @(posedge clk_i);
      #1;
   endtask : bsend

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      final_report();
   end

   // Main sequence
   initial begin
      logic [7:0] rv;
      int         deb [4];
      int         bt [3][3];
      deb  = '{16, 8, 4, 1};
      bt   = '{'{8'h0e, 1, 8}, '{8'h0e, 0, 1}, '{8'h0c, 1, 16}};
      rows = '{'{8'h4a, 1'b0, 8'h00, 8'h08}, '{8'h4b, 1'b0, 8'h00, 8'h00}, '{8'h4c, 1'b0, 8'h00, 8'ha2},
               '{8'h4d, 1'b0, 8'h00, 8'h48}, '{8'h4e, 1'b0, 8'h00, 8'hba}, '{8'h4f, 1'b0, 8'h00, 8'h4b},
               '{8'h50, 1'b0, 8'h00, 8'h88}, '{8'h49, 1'b0, 8'h00, 8'h00}, '{8'h4a, 1'b1, 8'hff, 8'h0f},
               '{8'h4b, 1'b1, 8'hff, 8'hf8}, '{8'h51, 1'b1, 8'hff, 8'h00}, '{8'h4c, 1'b1, 8'h5a, 8'h5a},
               '{8'h4a, 1'b1, 8'h08, 8'h08}, '{8'h4b, 1'b1, 8'h00, 8'h00}, '{8'h4c, 1'b1, 8'ha2, 8'ha2},
               '{8'h50, 1'b1, 8'h33, 8'h33}, '{8'h4d, 1'b1, 8'h5b, 8'h5b}, '{8'h4e, 1'b1, 8'h6c, 8'h6c},
               '{8'h4f, 1'b1, 8'h7d, 8'h7d}, '{8'h4d, 1'b1, 8'h48, 8'h48}, '{8'h4e, 1'b1, 8'hba, 8'hba},
               '{8'h4f, 1'b1, 8'h4b, 8'h4b}};
      // Reset for 16 cycles
      repeat (16) @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      chk8(supply_action_o, 8'h88);
      // Register table rows
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].addr, rows[i].wd);
         end
         rd(rows[i].addr, rv);
         chk8(rv, rows[i].ex);
      end
      chk8(supply_action_o, 8'h33);
      $display("Test done: register table");
      // Debounce count per select code
      for (int c = 0; c < 4; c++) begin
         wr(dff_pkg::ADDR_FILTER, 8'(c << 2));
         send(2'h0, 12'h800);
         for (int k = 1; k <= deb[c]; k++) begin
            send(2'h0, 12'hfff);
            chk1(ft.supply_high, k == deb[c]);
         end
         chk12(fl.data, 12'hfff);
         send(2'h0, 12'h800);
         chk1(ft.supply_high, 1'b0);
      end
      $display("Test done: debounce select");
      // Limit boundaries, then doubled limits
      send(2'h0, 12'ha20);
      chk1(ft.supply_high, 1'b0);
      send(2'h0, 12'ha21);
      chk1(ft.supply_high, 1'b1);
      send(2'h0, 12'h480);
      chk1(ft.supply_low, 1'b0);
      send(2'h0, 12'h47f);
      chk1(ft.supply_low, 1'b1);
      send(2'h2, 12'hbb0);
      chk1(ft.aux_upper, 1'b1);
      send(2'h2, 12'h4af);
      chk1(ft.aux_lower, 1'b1);
      send(2'h2, 12'h4b0);
      chk1(ft.aux_lower, 1'b0);
      wr(dff_pkg::ADDR_FILTER, 8'h0d);
      send(2'h0, 12'ha21);
      chk1(ft.supply_high, 1'b0);
      send(2'h0, 12'h8ff);
      chk1(ft.supply_low, 1'b1);
      send(2'h2, 12'hfff);
      chk1(ft.aux_upper, 1'b0);
      send(2'h2, 12'h95f);
      chk1(ft.aux_lower, 1'b1);
      wr(dff_pkg::ADDR_FILTER, 8'h0c);
      $display("Test done: limits and scaling");
      // Averaging modes on the load channel
      send(2'h0, 12'h100);
      wr(dff_pkg::ADDR_AVG, 8'h40);
      send(2'h0, 12'h301);
      chk12(fl.data, 12'h200);
      wr(dff_pkg::ADDR_AVG, 8'h80);
      send(2'h0, 12'h603);
      chk12(fl.data, 12'h300);
      // Reserved averaging code passes raw data
      wr(dff_pkg::ADDR_AVG, 8'hc0);
      send(2'h0, 12'h123);
      chk12(fl.data, 12'h123);
      // Per channel bypass, then averaging again
      for (int ch = 0; ch < 3; ch++) begin
         wr(dff_pkg::ADDR_AVG, 8'h40 | (8'h20 >> ch));
         send(2'(ch), 12'h0ab);
         chk12(fl.data, 12'h0ab);
         chk1(fl.valid, 1'b1);
         chk8(8'(fl.chan), 8'(ch));
         wr(dff_pkg::ADDR_AVG, 8'h40);
         send(2'(ch), 12'h0ad);
         chk12(fl.data, 12'h0ac);
      end
      // Unused channel code is ignored
      send(2'h3, 12'hfff);
      chk1(fl.valid, 1'b0);
      $display("Test done: averaging");
      // Battery short debounce: setting, below flag, target
      for (int t = 0; t < 3; t++) begin
         wr(dff_pkg::ADDR_FILTER, 8'(bt[t][0]));
         batt_below_i = 1'(bt[t][1]);
         bsend(1'b0);
         for (int k = 1; k <= bt[t][2]; k++) begin
            bsend(1'b1);
            chk1(ft.batt_short, k == bt[t][2]);
         end
      end
      $display("Test done: battery short");
      // Second reset restores defaults
      reset_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      chk1(fault_o.batt_short, 1'b0);
      rd(dff_pkg::ADDR_FILTER, rv);
      chk8(rv, 8'h08);
      $display("Test done: second reset");
      final_report();
   end
endmodule : tb_dff_fault_filter
